// ==== stop_mode_standby_control.sv ====
`timescale 1ns/1ps
// Deep standby controller: entry, clock gating, peripheral gating, wake
module stop_mode_standby_control (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Synchronous reset
	input wire logic stop_instr_in, // Standby instruction executed, pulse
	input wire logic cpu_on_fast_osc_in, // CPU clocked from internal fast osc
	input wire logic irq_pending_in, // Some request set and unmasked
	input wire logic ie_in, // CPU interrupt acceptance enabled
	input wire logic [2:0] osc_settle_select_in, // Settle wait code
	input wire logic ls_osc_run_in, // Low-speed oscillator runs now
	input wire logic ls_osc_sw_stop_opt_in, // Option: osc may be stopped
	input wire logic [1:0] counter_a_src_in, // Counter A clock select
	input wire logic [1:0] counter_b_src_in, // Counter B clock select
	input wire logic counter_a_run_in, // Counter A enabled
	input wire logic [1:0] timer_one_src_in, // Timer one clock select
	input wire logic [1:0] timer_two_src_in, // Timer two clock select
	input wire logic [1:0] serial_one_src_in, // Async one clock select
	input wire logic [1:0] serial_two_src_in, // Async two clock select
	input wire logic csu_ext_clk_in, // Clocked serial uses external clock
	output logic cpu_clk_en_out, // CPU clock gate
	output logic fast_osc_en_out, // Internal fast oscillator enable
	output logic crystal_en_out, // Crystal oscillator enable
	output logic ext_clk_accept_out, // External main clock accepted
	output logic ls_osc_en_out, // Low-speed oscillator enable
	output logic ram_hold_out, // RAM and port latches frozen
	output logic [9:0] periph_en_out, // Per-peripheral clock enables
	output logic in_stop_out, // Deep standby active
	output logic wake_vector_out, // Pulse: take vectored interrupt
	output logic wake_continue_out // Pulse: continue next instruction
);
	standby_pkg::state_t state_ff, nxt_state;
	logic [9:0] en_ff, nxt_en; // Peripheral enables
	logic clk_ff, nxt_clk; // CPU clock gate
	logic osc_ff, nxt_osc; // Main oscillator enables
	logic ls_ff, nxt_ls; // Low-speed osc enable
	logic wv_ff, nxt_wv; // Vector pulse
	logic wc_ff, nxt_wc; // Continue pulse
	logic ie_ff, nxt_ie; // Interrupt enable latched at wake
	settle_if sif ();

	// Wait timer for settle time
	settle_timer u_settle (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sif(sif)
	);

	// Enable set the peripherals get in deep standby; it is
	// recomputed every cycle so a changed clock choice counts
	logic [9:0] stop_en; // Enables while in deep standby

	// Per-peripheral gating in deep standby
	always_comb
	begin
		stop_en = '0;
		stop_en[0] = (counter_a_src_in == standby_pkg::CNT_SRC_EXT);
		stop_en[1] = (counter_b_src_in == standby_pkg::CNT_SRC_EXT);
		// A counter-A consumer is only live when counter A
		// itself keeps counting in standby
		// Timer one from counter
		stop_en[2] = (timer_one_src_in == standby_pkg::TMR1_SRC_CNTA)
			&& counter_a_run_in && stop_en[0];
		stop_en[3] = ((timer_two_src_in == standby_pkg::TMR2_SRC_LS)
			|| (timer_two_src_in == standby_pkg::TMR2_SRC_LS7)
			|| (timer_two_src_in == standby_pkg::TMR2_SRC_LS9)) && ls_ff;
		stop_en[4] = !(ls_osc_sw_stop_opt_in);
		stop_en[5] = (serial_one_src_in == standby_pkg::SER_SRC_CNTA)
			&& counter_a_run_in && stop_en[0];
		stop_en[6] = (serial_two_src_in == standby_pkg::SER_SRC_CNTA)
			&& counter_a_run_in && stop_en[0];
		stop_en[7] = csu_ext_clk_in;
		stop_en[8] = 1'b0;
		stop_en[9] = 1'b0;
	end

	// Next state and outputs
	always_comb
	begin
		nxt_state = state_ff;
		nxt_en = en_ff;
		nxt_clk = clk_ff;
		nxt_osc = osc_ff;
		nxt_ls = ls_ff;
		nxt_wv = 1'b0;
		nxt_wc = 1'b0;
		nxt_ie = ie_ff;
		// Settle timer idle unless a branch below starts it
		sif.start = 1'b0;
		sif.sel = osc_settle_select_in;
		case (state_ff)
			standby_pkg::ST_RUN:
			begin
				// Track the low-speed oscillator only while running
				nxt_ls = ls_osc_run_in;
				// Both fast CPU clocks allow entry, so the clock source
				// input is informational and not decoded here
				// Instruction only entry
				if (stop_instr_in)
				begin
					nxt_clk = 1'b0;
					if (irq_pending_in)
					begin
						nxt_state = standby_pkg::ST_HALT;
						nxt_ie = ie_in;
						sif.start = 1'b1;
					end
					else
					begin
						nxt_state = standby_pkg::ST_STOP;
						nxt_osc = 1'b0;
						nxt_en = stop_en;
					end
				end
			end
			standby_pkg::ST_STOP:
			begin
				nxt_ls = ls_ff;
				nxt_en = stop_en;
				if (irq_pending_in)
				begin
					nxt_state = standby_pkg::ST_SETTLE;
					nxt_osc = 1'b1;
					// Acceptance is latched at wake, not at resume
					nxt_ie = ie_in;
					sif.start = 1'b1;
				end
			end
			standby_pkg::ST_HALT, standby_pkg::ST_SETTLE:
			begin
				// Requests during the wait change nothing
				// Wait programmed time
				if (sif.done)
					nxt_state = standby_pkg::ST_RESUME;
			end
			standby_pkg::ST_RESUME:
			begin
				// Clock and peripherals come back together with
				// the one-cycle wake pulse
				// Vector or continue
				nxt_clk = 1'b1;
				nxt_en = standby_pkg::EN_RESET;
				nxt_wv = ie_ff;
				nxt_wc = !ie_ff;
				nxt_state = standby_pkg::ST_RUN;
			end
			// Unknown code: fall back to running
			default:
				nxt_state = standby_pkg::ST_RUN;
		endcase
	end

	// Register state; reset exits standby
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			// Everything running, no standby, no pulses
			state_ff <= standby_pkg::ST_RUN;
			en_ff <= standby_pkg::EN_RESET;
			clk_ff <= 1'b1;
			osc_ff <= 1'b1;
			ls_ff <= 1'b1;
			wv_ff <= 1'b0;
			wc_ff <= 1'b0;
			ie_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			en_ff <= nxt_en;
			clk_ff <= nxt_clk;
			osc_ff <= nxt_osc;
			ls_ff <= nxt_ls;
			wv_ff <= nxt_wv;
			wc_ff <= nxt_wc;
			ie_ff <= nxt_ie;
		end
	end

	logic stop_ff; // Registered standby flag
	// Standby flag taken from the next state, so in_stop_out
	// and ram_hold_out rise on the entry edge itself
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			stop_ff <= 1'b0;
		else
			stop_ff <= (nxt_state == standby_pkg::ST_STOP);
	end

	// Every output comes straight from a register
	// The three main clock controls share one enable: they
	// stop together and restart together on wake
	assign cpu_clk_en_out = clk_ff;
	assign fast_osc_en_out = osc_ff;
	assign crystal_en_out = osc_ff;
	assign ext_clk_accept_out = osc_ff;
	assign ls_osc_en_out = ls_ff;
	assign ram_hold_out = stop_ff;
	assign periph_en_out = en_ff;
	assign in_stop_out = stop_ff;
	// Wake pulses last exactly one cycle
	assign wake_vector_out = wv_ff;
	assign wake_continue_out = wc_ff;
endmodule

// ==== standby_pkg.sv ====
package standby_pkg;
	// Controller states, one-hot
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_STOP = 5'h02,
		ST_HALT = 5'h04,
		ST_SETTLE = 5'h08,
		ST_RESUME = 5'h10
	} state_t;
	// Width of the settle select field
	localparam int SEL_W = 3;
	// Width of the settle counter
	localparam int CNT_W = 20;
	// Settle wait in cycles for each select code: 2^(11+code)
	localparam logic [2:0] SETTLE_BASE_EXP = 3'h0;
	localparam int SETTLE_MIN_LOG2 = 11;
	// Count clock selections
	localparam logic [1:0] CNT_SRC_EXT = 2'h0;
	localparam logic [1:0] TMR1_SRC_CNTA = 2'h1;
	localparam logic [1:0] TMR2_SRC_LS = 2'h0;
	localparam logic [1:0] TMR2_SRC_LS7 = 2'h1;
	localparam logic [1:0] TMR2_SRC_LS9 = 2'h2;
	localparam logic [1:0] SER_SRC_CNTA = 2'h1;
	// Reset value of the enable bundle
	localparam logic [9:0] EN_RESET = 10'h3FF;
endpackage

// ==== settle_if.sv ====
`timescale 1ns/1ps
// Link between controller and its settle timer
interface settle_if;
	logic start; // Load and start the wait
	logic [standby_pkg::SEL_W-1:0] sel; // Wait length code
	logic done; // Wait expired, one-cycle pulse
	modport ctrl (output start, output sel, input done);
	modport tmr (input start, input sel, output done);
endinterface

// ==== settle_timer.sv ====
`timescale 1ns/1ps
// Counts the oscillation settle wait chosen by software
module settle_timer (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Synchronous reset
	settle_if.tmr sif // Start and done handshake
);
	localparam int CNT_W = standby_pkg::CNT_W; // Counter width
	logic [standby_pkg::CNT_W-1:0] cnt_ff; // Cycles left
	logic [standby_pkg::CNT_W-1:0] nxt_cnt;
	logic busy_ff; // Counting
	logic nxt_busy;
	logic done_ff; // Done pulse
	logic nxt_done;

	// Next count: load 2^(11+sel)-1 on start, else count down
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (sif.start)
		begin
			nxt_cnt = CNT_W'(({{(standby_pkg::CNT_W-1){1'b0}}, 1'b1}
				<< (standby_pkg::SETTLE_MIN_LOG2 + int'(sif.sel))) - 1);
			nxt_busy = 1'b1;
		end
		else if (busy_ff)
		begin
			if (cnt_ff == '0)
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
			else
				nxt_cnt = cnt_ff - CNT_W'(1);
		end
	end

	// Register the counter
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign sif.done = done_ff;
endmodule

// ==== standby_cpu_model.sv ====
`timescale 1ns/1ps
// CPU side: runs the standby instruction on request
module standby_cpu_model (
	input wire logic clk_in, // System clock
	input wire logic go_in, // Bench asks for the instruction
	input wire logic cpu_clk_en_in, // CPU clock gate from the controller
	output logic stop_instr_out = 1'b0 // Instruction executed, pulse
);
	always @(posedge clk_in)
		stop_instr_out <= go_in && cpu_clk_en_in && !stop_instr_out;
endmodule

// ==== stop_mode_standby_control_properties.sv ====
`timescale 1ns/1ps
// Port checks for the standby controller
module stop_mode_standby_control_properties (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic stop_instr_in, // Entry pulse
	input wire logic irq_pending_in, // Wake request
	input wire logic ls_osc_sw_stop_opt_in, // Watchdog option
	input wire logic csu_ext_clk_in, // Serial clock choice
	input wire logic cpu_clk_en_out, // CPU gate
	input wire logic fast_osc_en_out, // Fast osc
	input wire logic crystal_en_out, // Crystal
	input wire logic ext_clk_accept_out, // External clock
	input wire logic ls_osc_en_out, // Low-speed osc
	input wire logic ram_hold_out, // Freeze
	input wire logic [9:0] periph_en_out, // Enables
	input wire logic in_stop_out, // Standby
	input wire logic wake_vector_out, // Vector pulse
	input wire logic wake_continue_out // Continue pulse
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_ENTRY: assert property ($rose(in_stop_out) |-> $past(stop_instr_in))
		else $error("standby entered without instruction");
	AST_CANCEL: assert property ($rose(in_stop_out) |-> !$past(irq_pending_in))
		else $error("standby entered with request pending");
	AST_GATE: assert property (in_stop_out |-> !(cpu_clk_en_out |
		fast_osc_en_out | crystal_en_out | ext_clk_accept_out))
		else $error("clock left running in standby");
	AST_CORES: assert property (in_stop_out |-> periph_en_out[9:8] == 2'h0)
		else $error("timer or two-wire running in standby");
	AST_HOLD: assert property (in_stop_out |-> ram_hold_out)
		else $error("memory not frozen in standby");
	AST_LS: assert property (in_stop_out && $past(in_stop_out) |->
		$stable(ls_osc_en_out))
		else $error("low-speed oscillator changed in standby");
	AST_WDT: assert property (in_stop_out |->
		periph_en_out[4] == !ls_osc_sw_stop_opt_in)
		else $error("watchdog enable wrong in standby");
	AST_CSU: assert property (in_stop_out |->
		periph_en_out[7] == csu_ext_clk_in)
		else $error("clocked serial enable wrong in standby");
	AST_SETTLE: assert property ($fell(in_stop_out) |->
		!(wake_vector_out | wake_continue_out) [*8])
		else $error("resumed before settle wait");
	AST_ONE: assert property (!(wake_vector_out && wake_continue_out))
		else $error("both wake pulses at once");
	// Main scenarios
	cover property ($rose(in_stop_out));
	cover property (wake_vector_out);
	cover property (wake_continue_out);
	cover property ($fell(cpu_clk_en_out) && !in_stop_out);
endmodule

// ==== stop_mode_standby_control_bench.sv ====
`timescale 1ns/1ps
// Entry, wake, cancel and reset sequences
module stop_mode_standby_control_bench;
	logic clk_in = 1'b0; // Clock
	logic rst_in = 1'b1; // Reset
	logic go = 1'b0; // Request to CPU model
	logic irq = 1'b0; // Wake request
	logic ie = 1'b0; // Interrupt accept
	logic [19:0] cfg = 20'h086A9; // Packed clock selections
	logic stop_instr; // From CPU model
	logic clk_en, fast_en, xtal_en, ext_acc, ls_en, hold, in_stop, wv, wc;
	logic [9:0] pen; // Peripheral enables
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #50 clk_in = ~clk_in;
	standby_cpu_model CPU (.clk_in(clk_in), .go_in(go),
		.cpu_clk_en_in(clk_en), .stop_instr_out(stop_instr));
	stop_mode_standby_control DUT (.clk_in(clk_in), .rst_in(rst_in),
		.stop_instr_in(stop_instr), .cpu_on_fast_osc_in(cfg[19]),
		.irq_pending_in(irq), .ie_in(ie), .osc_settle_select_in(cfg[18:16]),
		.ls_osc_run_in(cfg[15]), .ls_osc_sw_stop_opt_in(cfg[14]),
		.counter_a_src_in(cfg[13:12]), .counter_b_src_in(cfg[11:10]),
		.counter_a_run_in(cfg[9]), .timer_one_src_in(cfg[8:7]),
		.timer_two_src_in(cfg[6:5]), .serial_one_src_in(cfg[4:3]),
		.serial_two_src_in(cfg[2:1]), .csu_ext_clk_in(cfg[0]),
		.cpu_clk_en_out(clk_en), .fast_osc_en_out(fast_en),
		.crystal_en_out(xtal_en), .ext_clk_accept_out(ext_acc),
		.ls_osc_en_out(ls_en), .ram_hold_out(hold), .periph_en_out(pen),
		.in_stop_out(in_stop), .wake_vector_out(wv), .wake_continue_out(wc));
	// Compare one result
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Wait cycles, then step off the edge
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask
	// Issue the standby instruction
	task enter();
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(3);
	endtask
	// Request wake, time the resume pulse
	task wake(input logic [15:0] exp, input int min);
		int n;
		n = 0;
		irq = 1'b1;
		while ((wv | wc) !== 1'b1 && n < 6000)
		begin
			tick(1);
			n++;
		end
		chk({wv, wc}, exp);
		chk(n >= min, 16'h0001);
		irq = 1'b0;
		tick(2);
	endtask
	// Report and stop
	task end_sim();
		$display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	// Main sequence
	initial
	begin
		tick(20);
		rst_in = 1'b0;
		chk({clk_en, fast_en, xtal_en, ext_acc, ls_en, hold, in_stop}, 16'h007C);
		chk(pen, 16'h03FF);
		enter();
		chk({in_stop, hold, clk_en, fast_en, xtal_en, ext_acc, ls_en}, 16'h0061);
		chk(pen, 16'h00BD);
		ie = 1'b1;
		wake(16'h0002, 2048);
		chk({in_stop, clk_en}, 16'h0001);
		cfg = 20'h8506A;
		enter();
		chk({in_stop, ls_en}, 16'h0002);
		chk(pen, 16'h0002);
		rst_in = 1'b1;
		tick(2);
		rst_in = 1'b0;
		tick(1);
		chk({in_stop, clk_en}, 16'h0001);
		chk(pen, 16'h03FF);
		cfg = 20'h086A9;
		irq = 1'b1;
		ie = 1'b0;
		enter();
		chk({in_stop, clk_en}, 16'h0000);
		wake(16'h0001, 2040);
		end_sim();
	end
endmodule
bind stop_mode_standby_control stop_mode_standby_control_properties chk_i (.*);
